// File: ekhp_consts.vh
// Purpose: constants of the emulated keyboard host port
// Assumes: included by ekhp_top.v
// Notes:   offsets are byte offsets on the ec register port
`ifndef EKHP_CONSTS_VH
`define EKHP_CONSTS_VH
// ==========================================
// ec register offsets
`define EKHP_OFS_HOST_DATA  8'h00
`define EKHP_OFS_STATUS     8'h04
`define EKHP_OFS_CTRL       8'h08
`define EKHP_OFS_AUX_DATA   8'h0C
`define EKHP_OFS_KBD_FLAG   8'h10
`define EKHP_OFS_IN_DATA    8'h14
`define EKHP_OFS_P92_EN     8'h18
`define EKHP_OFS_P92_BASE   8'h1C
// ==========================================
// host i/o addresses
`define EKHP_IO_DATA        16'h0060
`define EKHP_IO_CMD         16'h0064
`define EKHP_IO_P92         16'h0092
// ==========================================
// field positions
`define EKHP_ST_OBF         0
`define EKHP_ST_IBF         1
`define EKHP_ST_CMD         3
`define EKHP_ST_MOUSE       5
`define EKHP_CT_OIE         0
`define EKHP_CT_KFW         1
`define EKHP_CT_MSEL        2
`define EKHP_P92_RST        0
`define EKHP_P92_A20        1
// ==========================================
// reset values and timing
`define EKHP_P92_RESET      8'h00
`define EKHP_BYTE_ZERO      8'h00
`define EKHP_ALTERNATE_CPU_RESET_US     6
`define EKHP_TICK_US        1
`define EKHP_ALTERNATE_CPU_RESET_TICKS  (`EKHP_ALTERNATE_CPU_RESET_US / `EKHP_TICK_US)
`define EKHP_FIFO_W         9
`define EKHP_FIFO_D         16
`define EKHP_FIFO_AW        4
`endif

// File: ekhp_host_model.sv
// Purpose: host side issuing i/o cycles
// Assumes: one-cycle strobes on clk_sys
// Notes:   idle address and data show inverted values
`timescale 1ns/100ps
`default_nettype none
module ekhp_host_model (
  // clock
  input wire logic        clk_sys,
  // i/o cycle
  output logic            host_io_wr,
  output logic            host_io_rd,
  output logic [15:0]     host_addr,
  output logic [7:0]      host_wdata,
  input wire logic [7:0]  host_rdata,
  input wire logic        host_rdata_oe
);
  initial begin
    host_io_wr = 0;
    host_io_rd = 0;
    host_addr = 16'h0000;
    host_wdata = 8'h00;
  end
  task automatic io(input logic w, input logic [15:0] a,
                    input logic [7:0] d, output logic [8:0] q);
    @(posedge clk_sys) #1;
    host_addr = a;
    host_wdata = d;
    host_io_wr = w;
    host_io_rd = !w;
    @(posedge clk_sys) #1;
    host_io_wr = 0;
    host_io_rd = 0;
    host_addr = ~a;
    host_wdata = ~d;
    q = {host_rdata_oe, host_rdata};
  endtask
endmodule
`default_nettype wire

// File: ekhp_monitor.sv
// Purpose: port checker for ekhp_top
// Assumes: one clock, srst resets all
// Notes:   shadows ctrl, port92 enable, last ec byte
`timescale 1ns/100ps
`default_nettype none
`include "ekhp_consts.vh"
module ekhp_monitor (
  // clock and resets
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        main_power_good,
  // ec port
  input wire logic        ec_wr,
  input wire logic [7:0]  ec_addr,
  input wire logic [7:0]  ec_wdata,
  // host port
  input wire logic        host_io_wr,
  input wire logic        host_io_rd,
  input wire logic [15:0] host_addr,
  input wire logic [7:0]  host_rdata,
  input wire logic        host_rdata_oe,
  input wire logic        host_wr_ready,
  // irqs and pins
  input wire logic        keyboard_irq_source,
  input wire logic        mouse_irq_source,
  input wire logic        input_full_irq,
  input wire logic        output_read_irq,
  input wire logic        combined_system_reset_n
);
  logic       oie_ff, kfw_ff, msel_ff, p92_ff;
  logic [7:0] last_ff;
  wire w0  = ec_wr && ec_addr == `EKHP_OFS_HOST_DATA;
  wire wc  = ec_wr && ec_addr == `EKHP_OFS_AUX_DATA;
  wire r60 = host_io_rd && host_addr == `EKHP_IO_DATA;
  wire r92 = host_io_rd && host_addr == `EKHP_IO_P92;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ==========================================
  // shadow of ec settings
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {msel_ff, kfw_ff, oie_ff, p92_ff} <= 4'h0;
      last_ff <= 8'h00;
    end else if (ec_wr) begin
      if (ec_addr == `EKHP_OFS_CTRL)
        {msel_ff, kfw_ff, oie_ff} <= ec_wdata[2:0];
      if (ec_addr == `EKHP_OFS_P92_EN)
        p92_ff <= ec_wdata[0];
      if (w0 || wc)
        last_ff <= ec_wdata;
    end
  end
  // ==========================================
  // checks
  property p_in_irq;
    host_io_wr && host_wr_ready && (host_addr == `EKHP_IO_DATA ||
      host_addr == `EKHP_IO_CMD) |=> input_full_irq;
  endproperty
  a_in_irq: assert property (p_in_irq)
    else $error("input irq missing");
  property p_rd;
    r60 |=> output_read_irq && host_rdata_oe && host_rdata == $past(last_ff);
  endproperty
  a_rd: assert property (p_rd)
    else $error("host data read wrong");
  property p_p92_off;
    r92 && !p92_ff |=> !host_rdata_oe;
  endproperty
  a_p92_off: assert property (p_p92_off)
    else $error("disabled port92 driven");
  property p_p92_on;
    r92 && p92_ff |=> host_rdata_oe;
  endproperty
  a_p92_on: assert property (p_p92_on)
    else $error("enabled port92 silent");
  property p_koff;
    !oie_ff |=> !keyboard_irq_source;
  endproperty
  a_koff: assert property (p_koff)
    else $error("kbd irq while disabled");
  property p_moff;
    !oie_ff |=> !mouse_irq_source;
  endproperty
  a_moff: assert property (p_moff)
    else $error("mouse irq while disabled");
  property p_kon;
    w0 && oie_ff && !kfw_ff ##1 !ec_wr && !r60 |=> keyboard_irq_source;
  endproperty
  a_kon: assert property (p_kon)
    else $error("kbd irq not raised");
  property p_mon;
    wc && oie_ff && !msel_ff ##1 !ec_wr && !r60 |=> mouse_irq_source;
  endproperty
  a_mon: assert property (p_mon)
    else $error("mouse irq not raised");
  property p_kclr;
    r60 && !kfw_ff && !ec_wr ##1 !ec_wr |=> !keyboard_irq_source;
  endproperty
  a_kclr: assert property (p_kclr)
    else $error("kbd flag not cleared");
  property p_sys;
    !main_power_good |=> !combined_system_reset_n;
  endproperty
  a_sys: assert property (p_sys)
    else $error("combined reset missing");
endmodule
`default_nettype wire

// File: ekhp_top.v
// Purpose: emulated keyboard controller host port with alternate
//          reset and address gate port
// Assumes: host i/o strobes and ec strobes are one-cycle pulses
//          synchronous to clk_sys; clk_1mhz sampled as a level
// Notes:   host data and command writes queue in a fifo toward the ec
`timescale 1ns/100ps
`default_nettype none
`include "ekhp_consts.vh"

// ==========================================
// fifo of host writes
module ekhp_fifo #(
  parameter W  = `EKHP_FIFO_W,
  parameter D  = `EKHP_FIFO_D,
  parameter AW = `EKHP_FIFO_AW
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         srst,
  // fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg  [W-1:0] mem_ff [0:D-1];
  reg  [AW-1:0] wp_ff;
  reg  [AW-1:0] rp_ff;
  reg  [AW:0]   cnt_ff;
  reg           full_ff;
  reg           empty_ff;
  wire          push;
  wire          pop;
  reg  [AW:0]   nxt_cnt;
  assign in_ready  = ~full_ff;
  assign out_valid = ~empty_ff;
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid & ~full_ff;
  assign pop       = out_ready & ~empty_ff;
  always @* begin
    nxt_cnt = cnt_ff;
    if (push & ~pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop & ~push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end
  always @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
  always @(posedge clk_sys) begin
    if (srst) begin
      wp_ff    <= {AW{1'b0}};
      rp_ff    <= {AW{1'b0}};
      cnt_ff   <= {(AW+1){1'b0}};
      full_ff  <= 1'b0;
      empty_ff <= 1'b1;
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
      cnt_ff   <= nxt_cnt;
      full_ff  <= (nxt_cnt == D[AW:0]);
      empty_ff <= (nxt_cnt == {(AW+1){1'b0}});
    end
  end
endmodule
// ==========================================
// top
// Operation
// (R1) ec data or aux write sets output full
// (R2) data write sets kbd, aux sets mouse
// (R3) enable gates kbd flag onto irq source
// (R4) kbd flag clears at power up
// (R5) hw mode host read clears kbd flag
// (R6) fw select: firmware sets and clears kbd
// (R7) kbd flag register reads present flag
// (R8) enable low forces kbd irq low
// (R9) enable gates mouse flag onto irq source
// (R10) mouse flag clears at power up
// (R11) hw mode host read clears mouse flag
// (R12) enable low forces mouse irq low
// (R13) mouse select one means firmware flag
// (R14) host data or command write raises irq when the fifo is not full
// (R15) host data read raises ec irq
// (R16) port 92h decoded, reset to zero
// (R17) port 92h usable only when enabled
// (R18) disabled: writes ignored, reads float
// (R19) port 92h base: only valid writable
// (R20) combined reset from power and bus
// (R21) system routes kbd irq1, mouse irq12
// (R22) reset pulse counter on 1MHz clock
// (R23) host reads last ec written byte
module ekhp_top (
  // clock and well reset
  input  wire       clk_sys,
  input  wire       srst,
  // system reset sources
  input  wire       main_power_good,
  input  wire       lpc_reset_n,
  input  wire       clk_1mhz,
  // ec register port
  input  wire       ec_wr,
  input  wire       ec_rd,
  input  wire [7:0] ec_addr,
  input  wire [7:0] ec_wdata,
  output wire [7:0] ec_rdata,
  // host i/o port
  input  wire       host_io_wr,
  input  wire       host_io_rd,
  input  wire [15:0] host_addr,
  input  wire [7:0] host_wdata,
  output wire [7:0] host_rdata,
  output wire       host_rdata_oe,
  output wire       host_wr_ready,
  // interrupts and pins
  output wire       keyboard_irq_source,
  output wire       mouse_irq_source,
  output wire       input_full_irq,
  output wire       output_read_irq,
  output wire       combined_system_reset_n,
  output wire       alternate_addr_gate,
  output wire       keyboard_reset_out_n
);
  reg  [7:0] out_data_ff;
  reg        obf_ff;
  reg        kbd_hw_ff;
  reg        kbd_fw_ff;
  reg        mouse_hw_ff;
  reg        mouse_fw_ff;
  reg        oie_ff;
  reg        kfw_ff;
  reg        msel_ff;
  reg  [7:0] p92_ff;
  reg        p92_en_ff;
  reg        p92_valid_ff;
  reg  [7:0] ec_rdata_ff;
  reg  [7:0] host_rdata_ff;
  reg        host_oe_ff;
  reg        keyboard_irq_source_ff;
  reg        mouse_irq_source_ff;
  reg        ibf_irq_ff;
  reg        obr_irq_ff;
  reg        comb_rst_n_ff;
  reg        clk1m_d_ff;
  reg [3:0]  pulse_cnt_ff;
  reg        pulse_ff;
  reg        rst_bit_d_ff;
  reg        last_cmd_ff;
  wire       comb_rst;
  wire       ec_wr_data;
  wire       ec_wr_aux;
  wire       h_rd_data;
  wire       h_wr_in;
  wire       h_p92;
  wire       fifo_in_ready;
  wire       fifo_valid;
  wire [8:0] fifo_data;
  wire       fifo_pop;
  wire       tick;
  wire       nxt_kbd;
  wire       nxt_mouse;
  wire       kbd_now;
  wire       mouse_now;
  localparam [15:0] p92_io_addr = `EKHP_IO_P92;
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction
  // ==========================================
  // decode
  // (R20) combined reset
  assign comb_rst   = srst | ~main_power_good | ~lpc_reset_n;
  assign ec_wr_data = ec_wr & hit(ec_addr, `EKHP_OFS_HOST_DATA);
  assign ec_wr_aux  = ec_wr & hit(ec_addr, `EKHP_OFS_AUX_DATA);
  assign h_rd_data  = host_io_rd & (host_addr == `EKHP_IO_DATA);
  assign h_wr_in    = host_io_wr & ((host_addr == `EKHP_IO_DATA) |
                                    (host_addr == `EKHP_IO_CMD));
  // (R17) gated by enable
  assign h_p92      = p92_en_ff & (host_addr == `EKHP_IO_P92);
  assign fifo_pop   = ec_rd & hit(ec_addr, `EKHP_OFS_IN_DATA);
  assign tick       = clk_1mhz & ~clk1m_d_ff;
  // ==========================================
  // flags
  // (R5) hw clear on host read
  assign nxt_kbd   = ec_wr_data | (kbd_hw_ff & ~h_rd_data);
  // (R11) hw clear on host read
  assign nxt_mouse = ec_wr_aux | (mouse_hw_ff & ~h_rd_data);
  // (R7) present flag value
  assign kbd_now   = kfw_ff ? kbd_fw_ff : kbd_hw_ff;
  // (R13) zero selects hardware
  assign mouse_now = msel_ff ? mouse_fw_ff : mouse_hw_ff;
  always @(posedge clk_sys) begin
    if (srst) begin
      out_data_ff <= `EKHP_BYTE_ZERO;
      obf_ff      <= 1'b0;
      // (R4) (R10) flags clear at power up
      kbd_hw_ff   <= 1'b0;
      kbd_fw_ff   <= 1'b0;
      mouse_hw_ff <= 1'b0;
      mouse_fw_ff <= 1'b0;
      oie_ff      <= 1'b0;
      kfw_ff      <= 1'b0;
      msel_ff     <= 1'b0;
      p92_en_ff   <= 1'b0;
      p92_valid_ff <= 1'b0;
      last_cmd_ff <= 1'b0;
    end else begin
      // (R23) last written byte
      if (ec_wr_data | ec_wr_aux) begin
        out_data_ff <= ec_wdata;
      end
      // (R1) set wins over host read
      obf_ff <= ec_wr_data | ec_wr_aux | (obf_ff & ~h_rd_data);
      // (R2) (R4) per-source flags
      kbd_hw_ff   <= nxt_kbd;
      mouse_hw_ff <= nxt_mouse;
      // (R6) firmware latch
      if (ec_wr & hit(ec_addr, `EKHP_OFS_KBD_FLAG)) begin
        kbd_fw_ff <= ec_wdata[0];
      end
      // (R13) firmware mouse flag
      if (ec_wr & hit(ec_addr, `EKHP_OFS_STATUS)) begin
        mouse_fw_ff <= ec_wdata[`EKHP_ST_MOUSE];
      end
      if (ec_wr & hit(ec_addr, `EKHP_OFS_CTRL)) begin
        oie_ff  <= ec_wdata[`EKHP_CT_OIE];
        kfw_ff  <= ec_wdata[`EKHP_CT_KFW];
        msel_ff <= ec_wdata[`EKHP_CT_MSEL];
      end
      if (ec_wr & hit(ec_addr, `EKHP_OFS_P92_EN)) begin
        p92_en_ff <= ec_wdata[0];
      end
      // (R19) only valid bit stored
      if (ec_wr & hit(ec_addr, `EKHP_OFS_P92_BASE)) begin
        p92_valid_ff <= ec_wdata[0];
      end
      if (fifo_pop & fifo_valid) begin
        last_cmd_ff <= fifo_data[8];
      end
    end
  end
  // ==========================================
  // irq sources
  always @(posedge clk_sys) begin
    if (srst) begin
      keyboard_irq_source_ff    <= 1'b0;
      mouse_irq_source_ff    <= 1'b0;
      ibf_irq_ff <= 1'b0;
      obr_irq_ff <= 1'b0;
    end else begin
      // (R3) (R8) kbd gating
      keyboard_irq_source_ff    <= oie_ff & (kfw_ff ? kbd_fw_ff : nxt_kbd);
      // (R9) (R12) mouse gating
      mouse_irq_source_ff    <= oie_ff & (msel_ff ? mouse_fw_ff : nxt_mouse);
      // (R14) host write pulse
      ibf_irq_ff <= h_wr_in & fifo_in_ready;
      // (R15) host read pulse
      obr_irq_ff <= h_rd_data;
    end
  end
  // ==========================================
  // host write queue
  ekhp_fifo #(
    .W  (`EKHP_FIFO_W),
    .D  (`EKHP_FIFO_D),
    .AW (`EKHP_FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (h_wr_in),
    .in_ready  (fifo_in_ready),
    .in_data   ({host_addr == `EKHP_IO_CMD, host_wdata}),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );
  // ==========================================
  // ec read mux
  always @(posedge clk_sys) begin
    if (srst) begin
      ec_rdata_ff <= `EKHP_BYTE_ZERO;
    end else if (ec_rd) begin
      ec_rdata_ff <= `EKHP_BYTE_ZERO;
      case (ec_addr)
        `EKHP_OFS_STATUS: begin
          ec_rdata_ff[`EKHP_ST_OBF]   <= obf_ff;
          ec_rdata_ff[`EKHP_ST_IBF]   <= fifo_valid;
          ec_rdata_ff[`EKHP_ST_CMD]   <= last_cmd_ff;
          ec_rdata_ff[`EKHP_ST_MOUSE] <= mouse_now;
        end
        `EKHP_OFS_CTRL: begin
          ec_rdata_ff[`EKHP_CT_OIE]  <= oie_ff;
          ec_rdata_ff[`EKHP_CT_KFW]  <= kfw_ff;
          ec_rdata_ff[`EKHP_CT_MSEL] <= msel_ff;
        end
        // (R7) readback of flag
        `EKHP_OFS_KBD_FLAG: begin
          ec_rdata_ff[0] <= kbd_now;
        end
        `EKHP_OFS_IN_DATA: begin
          ec_rdata_ff <= fifo_valid ? fifo_data[7:0] : `EKHP_BYTE_ZERO;
        end
        `EKHP_OFS_P92_EN: begin
          ec_rdata_ff[0] <= p92_en_ff;
        end
        `EKHP_OFS_P92_BASE: begin
          ec_rdata_ff <= p92_io_addr[7:0] | {7'h00, p92_valid_ff};
        end
        default: begin
          ec_rdata_ff <= `EKHP_BYTE_ZERO;
        end
      endcase
    end
  end
  // ==========================================
  // host reads and port 92h
  always @(posedge clk_sys) begin
    if (comb_rst) begin
      // (R16) zero on combined reset
      p92_ff        <= `EKHP_P92_RESET;
      host_rdata_ff <= `EKHP_BYTE_ZERO;
      host_oe_ff    <= 1'b0;
    end else begin
      // (R18) writes ignored when off
      if (host_io_wr & h_p92) begin
        p92_ff <= host_wdata;
      end
      host_oe_ff <= 1'b0;
      if (h_rd_data) begin
        host_rdata_ff <= out_data_ff;
        host_oe_ff    <= 1'b1;
      end else if (host_io_rd & (host_addr == `EKHP_IO_CMD)) begin
        host_rdata_ff <= `EKHP_BYTE_ZERO;
        host_rdata_ff[`EKHP_ST_OBF]   <= obf_ff;
        host_rdata_ff[`EKHP_ST_IBF]   <= fifo_valid;
        host_rdata_ff[`EKHP_ST_CMD]   <= last_cmd_ff;
        host_rdata_ff[`EKHP_ST_MOUSE] <= mouse_now;
        host_oe_ff <= 1'b1;
      // (R18) reads float when off
      end else if (host_io_rd & h_p92) begin
        host_rdata_ff <= p92_ff;
        host_oe_ff    <= 1'b1;
      end
    end
  end
  // ==========================================
  // alternate cpu reset pulse
  always @(posedge clk_sys) begin
    if (comb_rst) begin
      comb_rst_n_ff <= 1'b0;
      clk1m_d_ff    <= 1'b0;
      pulse_cnt_ff  <= 4'h0;
      pulse_ff      <= 1'b0;
      rst_bit_d_ff  <= 1'b0;
    end else begin
      comb_rst_n_ff <= 1'b1;
      clk1m_d_ff    <= clk_1mhz;
      rst_bit_d_ff  <= p92_ff[`EKHP_P92_RST];
      if (~pulse_ff & p92_ff[`EKHP_P92_RST] & ~rst_bit_d_ff) begin
        pulse_ff     <= 1'b1;
        pulse_cnt_ff <= 4'h0;
      // (R22) count 1 MHz edges
      end else if (pulse_ff & tick) begin
        if (pulse_cnt_ff == `EKHP_ALTERNATE_CPU_RESET_TICKS - 1) begin
          pulse_ff <= 1'b0;
        end
        pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
      end
    end
  end
  // ==========================================
  // outputs
  assign ec_rdata                = ec_rdata_ff;
  assign host_rdata              = host_rdata_ff;
  assign host_rdata_oe           = host_oe_ff;
  assign host_wr_ready           = fifo_in_ready;
  assign keyboard_irq_source     = keyboard_irq_source_ff;
  assign mouse_irq_source        = mouse_irq_source_ff;
  assign input_full_irq          = ibf_irq_ff;
  assign output_read_irq         = obr_irq_ff;
  assign combined_system_reset_n = comb_rst_n_ff;
  assign alternate_addr_gate     = p92_ff[`EKHP_P92_A20];
  assign keyboard_reset_out_n    = ~pulse_ff;
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for ekhp_top
// Assumes: monitor and host model compiled first
// Notes:   reference state kept in bits and a queue
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_sys = 0, clk_1mhz = 0, srst, main_power_good, lpc_reset_n;
  logic        ec_wr, ec_rd;
  logic [7:0]  ec_addr, ec_wdata, ec_rdata, host_rdata, d;
  wire  [15:0] host_addr;
  wire  [7:0]  host_wdata;
  wire         host_io_wr, host_io_rd;
  logic        host_rdata_oe, host_wr_ready, keyboard_irq_source;
  logic        mouse_irq_source, input_full_irq, output_read_irq;
  logic        combined_system_reset_n, alternate_addr_gate;
  logic        keyboard_reset_out_n;
  logic [8:0]  r;
  int          error_cnt = 0, samples_checked = 0, i, n;
  bit          output_full_status, kf, mf, fk, fm, oie, kfw, msel, cmd;
  bit   [7:0]  last;
  bit   [8:0]  q[$];
  always #50 clk_sys = ~clk_sys;
  always #500 clk_1mhz = ~clk_1mhz;
  ekhp_top ekhp_top_inst (.clk_sys, .srst, .main_power_good, .lpc_reset_n,
    .clk_1mhz, .ec_wr, .ec_rd, .ec_addr, .ec_wdata, .ec_rdata, .host_io_wr,
    .host_io_rd, .host_addr, .host_wdata, .host_rdata, .host_rdata_oe,
    .host_wr_ready, .keyboard_irq_source, .mouse_irq_source,
    .input_full_irq, .output_read_irq, .combined_system_reset_n,
    .alternate_addr_gate, .keyboard_reset_out_n);
  ekhp_host_model ekhp_host_model_inst (.clk_sys, .host_io_wr, .host_io_rd,
    .host_addr, .host_wdata, .host_rdata, .host_rdata_oe);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic ec(input logic w, input logic [7:0] a, v);
    @(posedge clk_sys) #1;
    ec_addr = a;
    ec_wdata = v;
    ec_wr = w;
    ec_rd = !w;
    @(posedge clk_sys) #1;
    ec_wr = 0;
    ec_rd = 0;
  endtask
  task automatic ew(input logic [7:0] a, v);
    ec(1, a, v);
    if (a == 8'h00 || a == 8'h0C) begin
      output_full_status = 1;
      last = v;
      if (a == 8'h00) kf = 1;
      else mf = 1;
    end
    if (a == 8'h08) {msel, kfw, oie} = v[2:0];
    if (a == 8'h10) fk = v[0];
    if (a == 8'h04) fm = v[5];
  endtask
  task automatic er(input logic [7:0] a, e);
    ec(0, a, 8'h00);
    chk("ec_rdata", {1'b0, e}, {1'b0, ec_rdata});
  endtask
  function automatic logic [7:0] st();
    return {2'b00, msel ? fm : mf, 1'b0, cmd, 1'b0, q.size() > 0, output_full_status};
  endfunction
  task automatic hr(input logic [15:0] a);
    ekhp_host_model_inst.io(0, a, 8'h00, r);
    if (a == 16'h0060) begin
      chk("host_rdata", {1'b1, last}, r);
      {output_full_status, kf, mf} = 3'h0;
    end else if (a == 16'h0064) begin
      chk("host_status", {1'b1, st()}, r);
    end
  endtask
  task automatic hw(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys) #1;
    chk("host_wr_ready", {8'h00, q.size() < 16}, {8'h00, host_wr_ready});
    ekhp_host_model_inst.io(1, a, v, r);
    if (a != 16'h0092 && q.size() < 16) q.push_back({a == 16'h0064, v});
  endtask
  task automatic irqs();
    @(posedge clk_sys) #1;
    chk("irq", {7'h00, oie & (kfw ? fk : kf), oie & (msel ? fm : mf)},
        {7'h00, keyboard_irq_source, mouse_irq_source});
  endtask
  initial begin
    #3000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {srst, main_power_good, lpc_reset_n, ec_wr, ec_rd} = 5'h1C;
    {ec_addr, ec_wdata} = 16'h0000;
    n = $urandom(88661);
    repeat (4) @(posedge clk_sys);
    #1 srst = 0;
    er(8'h04, 8'h00);
    er(8'h10, 8'h00);
    er(8'h1C, 8'h92);
    irqs();
    $display("test reset done");
    ew(8'h08, 8'h01);
    for (i = 0; i < 2; i++) begin
      d = $urandom;
      ew(i ? 8'h0C : 8'h00, d);
      irqs();
      er(8'h04, st());
      hr(16'h0064);
      er(8'h10, {7'h00, kfw ? fk : kf});
      hr(16'h0060);
      irqs();
    end
    ew(8'h08, 8'h00);
    ew(8'h00, d);
    ew(8'h0C, d);
    irqs();
    hr(16'h0060);
    $display("test hardware flags done");
    ew(8'h08, 8'h07);
    ew(8'h10, 8'h01);
    ew(8'h04, 8'h20);
    irqs();
    er(8'h10, 8'h01);
    hr(16'h0060);
    irqs();
    ew(8'h10, 8'h00);
    ew(8'h04, 8'h00);
    irqs();
    ew(8'h08, 8'h01);
    $display("test firmware flags done");
    for (i = 0; i < 17; i++)
      hw(i[0] ? 16'h0064 : 16'h0060, 8'($urandom));
    hr(16'h0064);
    for (i = 0; i < 17; i++) begin
      d = 8'h00;
      if (q.size() > 0) {cmd, d} = q.pop_front();
      er(8'h14, d);
      er(8'h04, st());
    end
    $display("test input queue done");
    hw(16'h0092, 8'h03);
    hr(16'h0092);
    chk("p92_oe", 9'h000, {r[8], 8'h00});
    ew(8'h18, 8'h01);
    hr(16'h0092);
    chk("p92", 9'h100, r);
    hw(16'h0092, 8'h03);
    chk("a20", 9'h001, {8'h00, alternate_addr_gate});
    @(posedge clk_sys) #1;
    for (n = 0; n < 200 && !keyboard_reset_out_n; n++) @(posedge clk_sys) #1;
    chk("pulse", 9'h001, {8'h00, n > 50 && n < 61});
    ew(8'h1C, 8'hFF);
    er(8'h1C, 8'h93);
    for (i = 0; i < 2; i++) begin
      hw(16'h0092, 8'h02);
      main_power_good = i[0];
      lpc_reset_n = !i[0];
      repeat (2) @(posedge clk_sys);
      #1 chk("sys_rst_n", 9'h000, {8'h00, combined_system_reset_n});
      {main_power_good, lpc_reset_n} = 2'h3;
      hr(16'h0092);
      chk("p92", 9'h100, r);
    end
    $display("test port92 done");
    report_and_stop();
  end
endmodule
bind ekhp_top ekhp_monitor ekhp_monitor_inst (.clk_sys, .srst,
  .main_power_good, .ec_wr, .ec_addr, .ec_wdata, .host_io_wr, .host_io_rd,
  .host_addr, .host_rdata, .host_rdata_oe, .host_wr_ready,
  .keyboard_irq_source, .mouse_irq_source, .input_full_irq,
  .output_read_irq, .combined_system_reset_n);
`default_nettype wire
